// ==== sim/tb.sv ====
// self-checking bench for the watchdog/interval timer
`timescale 1ns/100ps
`include "wdit_consts.svh"
module tb;
	import wdit_pkg::*;
	logic       core_clk;       // 200 MHz core clock
	logic       resetn;         // synchronous reset, active low
	wdit_addr_t avs_address;    // bus byte address
	logic       avs_read;       // bus read strobe
	logic       avs_write;      // bus write strobe
	wdit_word_t avs_writedata;  // bus write data
	wdit_be_t   avs_byteenable; // bus byte lanes
	wdit_word_t avs_readdata;   // bus read data
	logic       avs_waitrequest;// slave stall
	logic       intervalIrq;    // interval interrupt level
	logic       internalReset;  // watchdog reset pulse
	logic       resetOut;       // gated external reset
	logic [7:0] expQ[$];        // expected read data, oldest first
	int         fails;          // mismatches
	int         checked;        // comparisons made
	int         n;              // cycles waited
	logic [7:0] rv;             // random counter value
	int         div[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096}; // divider per select code

	wdit_watchdog_timer dut (
		.core_clk       (core_clk),
		.resetn         (resetn),
		.avs_address    (avs_address),
		.avs_read       (avs_read),
		.avs_write      (avs_write),
		.avs_writedata  (avs_writedata),
		.avs_byteenable (avs_byteenable),
		.avs_readdata   (avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.intervalIrq    (intervalIrq),
		.internalReset  (internalReset),
		.resetOut       (resetOut)
	);

	// free-running clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// counts, verdict, end of run
	task automatic tally_and_finish();
		$display("checked %0d, fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// compare one read word against its note
	task automatic check_rd(input logic [7:0] exp, input wdit_word_t got);
		checked++;
		if (got !== {24'h000000, exp}) begin
			fails++;
			$display("[FAIL] %0t read data %h, expected %h", $time, got, exp);
		end
	endtask

	// compare one output bit
	task automatic check_bit(input logic got, input logic exp, input string what);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t %s is %b, expected %b", $time, what, got, exp);
		end
	endtask

	// one bus access, held until waitrequest is sampled low
	task automatic bus_acc(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
		int w;
		w = 0;
		avs_address    <= {idx, 2'b00};
		avs_writedata  <= {24'($urandom()), d};
		avs_byteenable <= be;
		avs_read       <= !wr;
		avs_write      <= wr;
		do begin
			@(posedge core_clk);
			w++;
		end while (avs_waitrequest !== 1'b0 && w < 20);
		if (w >= 20) begin
			fails++;
			$display("[FAIL] %0t bus access never answered", $time);
		end
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask

	// read with its expected value noted first
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		expQ.push_back(exp);
		bus_acc(1'b0, idx, 8'h00, 4'hf);
	endtask

	// full-lane write
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus_acc(1'b1, idx, d, 4'hf);
	endtask

	// wait for irq (rst=0) or internal reset (rst=1), bounded
	task automatic wait_hi(input bit rst, input int lim, output int cyc);
		cyc = 0;
		do begin
			@(posedge core_clk);
			cyc++;
		end while ((rst ? internalReset : intervalIrq) !== 1'b1 && cyc < lim);
	endtask

	// read monitor: oldest note against each completed read
	always @(posedge core_clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			if (expQ.size() == 0) begin
				fails++;
				$display("[FAIL] %0t read with no expectation", $time);
			end else
				check_rd(expQ.pop_front(), avs_readdata);
		end
	end

	// hang guard
	initial begin
		repeat (30000) @(posedge core_clk);
		fails++;
		$display("[FAIL] %0t run timed out", $time);
		tally_and_finish();
	end

	// main sequence
	initial begin
		resetn = 1'b0;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		avs_byteenable = '0;
		fails = 0;
		checked = 0;
		void'($urandom(32'h64668c5b));
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		// reset values, unmapped place, stopped counter, flag set attempt
		rd(`WDIT_IDX_CTRL_STATUS, 8'h18);
		rd(`WDIT_IDX_COUNT, 8'h00);
		rd(`WDIT_IDX_RSTCS_RD, 8'h3f);
		rd(8'h10, 8'h00);
		wr(`WDIT_IDX_COUNT, 8'h5a);
		wr(`WDIT_IDX_CTRL_STATUS, 8'h80);
		rd(`WDIT_IDX_COUNT, 8'h00);
		rd(`WDIT_IDX_CTRL_STATUS, 8'h18);
		// random loads at the slowest select, well before its first tick
		wr(`WDIT_IDX_CTRL_STATUS, 8'h27);
		for (int i = 0; i < 8; i++) begin
			rv = 8'($urandom());
			wr(`WDIT_IDX_COUNT, rv);
			bus_acc(1'b1, `WDIT_IDX_COUNT, ~rv, 4'he);
			rd(`WDIT_IDX_COUNT, rv);
		end
		wr(`WDIT_IDX_CTRL_STATUS, 8'h00);
		// every clock select: time from load of 0xff to overflow
		for (int k = 0; k < 8; k++) begin
			wr(`WDIT_IDX_CTRL_STATUS, 8'h20 | 8'(k));
			wr(`WDIT_IDX_COUNT, 8'hff);
			wait_hi(1'b0, div[k] + 20, n);
			check_bit(n >= div[k] - 8 && n <= div[k] + 4, 1'b1, "tick spacing");
			if (k == 0)
				wr(`WDIT_IDX_CTRL_STATUS, 8'h20);
			rd(`WDIT_IDX_CTRL_STATUS, 8'hb8 | 8'(k));
			check_bit(intervalIrq, 1'b1, "interval irq");
			wr(`WDIT_IDX_CTRL_STATUS, 8'h00);
			rd(`WDIT_IDX_CTRL_STATUS, 8'h18);
			check_bit(intervalIrq, 1'b0, "irq after stop");
		end
		// watchdog overflow with the external output enabled, then disabled
		for (int oe = 1; oe >= 0; oe--) begin
			wr(`WDIT_IDX_RSTCS_WR, {1'b0, oe[0], 6'h00});
			wr(`WDIT_IDX_CTRL_STATUS, 8'h60);
			wr(`WDIT_IDX_COUNT, 8'hff);
			wait_hi(1'b1, 20, n);
			check_bit(internalReset, 1'b1, "internal reset");
			check_bit(resetOut, oe[0], "reset output");
			check_bit(intervalIrq, 1'b0, "irq in watchdog mode");
			@(posedge core_clk);
			check_bit(internalReset, 1'b0, "reset pulse width");
			rd(`WDIT_IDX_CTRL_STATUS, 8'h18);
			rd(`WDIT_IDX_RSTCS_RD, {1'b1, oe[0], 6'h3f});
			if (oe == 1) begin
				wr(`WDIT_IDX_RSTCS_WR, 8'h40);
				rd(`WDIT_IDX_RSTCS_RD, 8'h7f);
			end
		end
		// reset pin clears the watchdog flag
		resetn <= 1'b0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		rd(`WDIT_IDX_RSTCS_RD, 8'h3f);
		tally_and_finish();
	end
endmodule // tb

// ==== verilog/wdit_consts.svh ====
// register offsets, field positions, reset values and prescale counts of the watchdog/interval timer
`ifndef WDIT_CONSTS_SVH
`define WDIT_CONSTS_SVH

// register indices; byte address on the bus is four times the index
`define WDIT_IDX_CTRL_STATUS    8'ha8
`define WDIT_IDX_COUNT          8'ha9
`define WDIT_IDX_RSTCS_WR       8'haa
`define WDIT_IDX_RSTCS_RD       8'hab

// timer control/status fields
`define WDIT_WRAP_BIT           7
`define WDIT_MODE_BIT           6
`define WDIT_RUN_BIT            5
`define WDIT_CKS_MSB            2
`define WDIT_CKS_LSB            0
`define WDIT_CTRL_FILL          2'h3

// reset control/status fields
`define WDIT_WDOG_BIT           7
`define WDIT_OUTEN_BIT          6
`define WDIT_RSTCS_FILL         6'h3f

// reset values and counter maximum
`define WDIT_COUNT_RESET        8'h00
`define WDIT_COUNT_MAX          8'hff
`define WDIT_CKS_RESET          3'h0

// prescaler width and the number of low divider bits per clock select code
`define WDIT_PRESCALE_W         12
`define WDIT_DIV2_BITS          4'd1
`define WDIT_DIV32_BITS         4'd5
`define WDIT_DIV64_BITS         4'd6
`define WDIT_DIV128_BITS        4'd7
`define WDIT_DIV256_BITS        4'd8
`define WDIT_DIV512_BITS        4'd9
`define WDIT_DIV2048_BITS       4'd11
`define WDIT_DIV4096_BITS       4'd12

`endif

// ==== verilog/wdit_pkg.sv ====
// types shared by the watchdog/interval timer
package wdit_pkg;
	typedef logic [9:0]  wdit_addr_t;   // avalon byte address
	typedef logic [31:0] wdit_word_t;   // avalon data word
	typedef logic [3:0]  wdit_be_t;     // avalon byte enables
	typedef enum logic {
		BUS_IDLE,
		BUS_ACK
	} wdit_bus_state_t;
endpackage

// ==== verilog/wdit_watchdog_timer.sv ====
// watchdog/interval timer with an avalon-mm register slave
`timescale 1ns/100ps
`include "wdit_consts.svh"

// Operation
// - timer-run low holds counter at zero
// - interrupts allowed only while timer runs
// - interval mode requests interrupt per overflow
// - watchdog mode overflow makes internal reset
// - clock select picks one of eight dividers
// - overflow flag sets on wrap to zero
// - writing one to overflow flag ignored
// - output enable gates external reset output
// - reset flag set by watchdog, cleared by software
module wdit_watchdog_timer (
	input  wire logic              core_clk,
	input  wire logic              resetn,
	input  wire wdit_pkg::wdit_addr_t avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire wdit_pkg::wdit_word_t avs_writedata,
	input  wire wdit_pkg::wdit_be_t   avs_byteenable,
	output wdit_pkg::wdit_word_t   avs_readdata,
	output logic                   avs_waitrequest,
	output logic                   intervalIrq,
	output logic                   internalReset,
	output logic                   resetOut
);
	import wdit_pkg::*;

	// bus slave state
	wdit_bus_state_t busState_reg, busState_next;  // idle or acknowledging
	logic            waitReq_reg,  waitReq_next;   // waitrequest flop
	logic [31:0]     readData_reg, readData_next;  // captured read word

	// timer state
	logic [`WDIT_PRESCALE_W-1:0] prescale_reg, prescale_next; // free divider
	logic [7:0] count_reg,   count_next;    // up counter
	logic       wrapFlag_reg, wrapFlag_next; // overflow flag
	logic       mode_reg,    mode_next;     // 1 watchdog, 0 interval
	logic       run_reg,     run_next;      // timer run
	logic [2:0] cks_reg,     cks_next;      // clock select
	logic       wrapArm_reg,  wrapArm_next;  // flag read as one
	logic       wdogFlag_reg, wdogFlag_next; // watchdog reset flag
	logic       wdogArm_reg,  wdogArm_next;  // reset flag read as one
	logic       reset_output_enable_reg,   reset_output_enable_next;    // reset output enable
	logic       irq_reg,     irq_next;      // interval request
	logic       intRst_reg,  intRst_next;   // internal reset pulse
	logic       extRst_reg,  extRst_next;   // external reset pulse
	// decode helpers
	logic [7:0]  wordIdx;                   // register index
	logic        busDone;                   // completion edge
	logic        doWrite;                   // write takes effect
	logic [7:0]  wdata;                     // low write byte
	logic [7:0]  readMux;                   // selected register
	logic [3:0]  divBits;                   // divider bits in use
	logic [`WDIT_PRESCALE_W-1:0] divMask;   // low bits that must be ones
	logic        tick;                      // counter enable pulse
	logic        overflow;                  // wrap this cycle

	assign wordIdx = avs_address[9:2];
	assign busDone = (busState_reg == BUS_ACK);
	assign doWrite = busDone && avs_write && avs_byteenable[0];
	assign wdata   = avs_writedata[7:0];

	// register read multiplexer, unmapped reads give zero
	always_comb begin
		case (wordIdx)
			`WDIT_IDX_CTRL_STATUS: readMux = {wrapFlag_reg, mode_reg, run_reg, `WDIT_CTRL_FILL, cks_reg};
			`WDIT_IDX_COUNT:       readMux = count_reg;
			`WDIT_IDX_RSTCS_RD:    readMux = {wdogFlag_reg, reset_output_enable_reg, `WDIT_RSTCS_FILL};
			default:               readMux = 8'h00;
		endcase
	end

	// bus handshake: one wait cycle, then waitrequest low for one cycle
	always_comb begin
		busState_next = busState_reg;
		waitReq_next  = waitReq_reg;
		readData_next = readData_reg;
		case (busState_reg)
			BUS_IDLE: begin
				if (avs_read || avs_write) begin
					busState_next = BUS_ACK;
					waitReq_next  = 1'b0;
					readData_next = {24'h000000, readMux};
				end
			end
			BUS_ACK: begin
				busState_next = BUS_IDLE;
				waitReq_next  = 1'b1;
			end
			default: begin
				busState_next = BUS_IDLE;
				waitReq_next  = 1'b1;
			end
		endcase
	end

	// bus registers
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			busState_reg <= BUS_IDLE;
			waitReq_reg  <= 1'b1;
			readData_reg <= 32'h00000000;
		end else begin
			busState_reg <= busState_next;
			waitReq_reg  <= waitReq_next;
			readData_reg <= readData_next;
		end
	end

	// divider selection per clock select code
	always_comb begin
		case (cks_reg)
			3'h0:    divBits = `WDIT_DIV2_BITS;
			3'h1:    divBits = `WDIT_DIV32_BITS;
			3'h2:    divBits = `WDIT_DIV64_BITS;
			3'h3:    divBits = `WDIT_DIV128_BITS;
			3'h4:    divBits = `WDIT_DIV256_BITS;
			3'h5:    divBits = `WDIT_DIV512_BITS;
			3'h6:    divBits = `WDIT_DIV2048_BITS;
			default: divBits = `WDIT_DIV4096_BITS;
		endcase
		divMask = `WDIT_PRESCALE_W'((13'h0001 << divBits) - 13'h0001);
	end

	assign tick     = run_reg && ((prescale_reg & divMask) == divMask);
	assign overflow = tick && (count_reg == `WDIT_COUNT_MAX) && !(doWrite && wordIdx == `WDIT_IDX_COUNT);
	// timer next state
	always_comb begin
		count_next    = count_reg;
		wrapFlag_next = wrapFlag_reg;
		mode_next     = mode_reg;
		run_next      = run_reg;
		cks_next      = cks_reg;
		wrapArm_next  = wrapArm_reg;
		wdogFlag_next = wdogFlag_reg;
		wdogArm_next  = wdogArm_reg;
		reset_output_enable_next    = reset_output_enable_reg;
		// divider runs only with the timer, so ticks start aligned
		prescale_next = run_reg ? prescale_reg + 1'b1 : '0;
		// counter stopped at zero or stepping on each tick
		if (!run_reg) begin
			count_next = `WDIT_COUNT_RESET;
		end else if (tick) begin
			count_next = count_reg + 8'h01;
		end
		// software access effects
		if (busDone && avs_read && wordIdx == `WDIT_IDX_CTRL_STATUS && readData_reg[`WDIT_WRAP_BIT]) begin
			wrapArm_next = 1'b1;
		end
		if (busDone && avs_read && wordIdx == `WDIT_IDX_RSTCS_RD && readData_reg[`WDIT_WDOG_BIT]) begin
			wdogArm_next = 1'b1;
		end
		if (doWrite) begin
			case (wordIdx)
				`WDIT_IDX_CTRL_STATUS: begin
					mode_next = wdata[`WDIT_MODE_BIT];
					run_next  = wdata[`WDIT_RUN_BIT];
					cks_next  = wdata[`WDIT_CKS_MSB:`WDIT_CKS_LSB];
					// only a zero after a read of one clears, a one does nothing
					if (!wdata[`WDIT_WRAP_BIT] && wrapArm_reg) begin
						wrapFlag_next = 1'b0;
						wrapArm_next  = 1'b0;
					end
				end
				`WDIT_IDX_COUNT: begin
					if (run_reg) begin
						count_next = wdata;
					end
				end
				`WDIT_IDX_RSTCS_WR: begin
					reset_output_enable_next = wdata[`WDIT_OUTEN_BIT];
					if (!wdata[`WDIT_WDOG_BIT] && wdogArm_reg) begin
						wdogFlag_next = 1'b0;
						wdogArm_next  = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// hardware set wins over a clear in the same cycle
		if (overflow) begin
			wrapFlag_next = 1'b1;
			if (mode_reg) begin
				wdogFlag_next = 1'b1;
			end
		end
		// the internal reset returns the timer side to its reset state
		if (intRst_reg) begin
			prescale_next = '0;
			count_next    = `WDIT_COUNT_RESET;
			wrapFlag_next = 1'b0;
			wrapArm_next  = 1'b0;
			mode_next     = 1'b0;
			run_next      = 1'b0;
			cks_next      = `WDIT_CKS_RESET;
		end
		irq_next    = wrapFlag_next && run_next && !mode_next;
		intRst_next = overflow && mode_reg;
		extRst_next = overflow && mode_reg && reset_output_enable_reg;
	end

	// timer registers; the reset pin also clears the reset flag
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			prescale_reg <= '0;
			count_reg    <= `WDIT_COUNT_RESET;
			wrapFlag_reg <= 1'b0;
			mode_reg     <= 1'b0;
			run_reg      <= 1'b0;
			cks_reg      <= `WDIT_CKS_RESET;
			wrapArm_reg  <= 1'b0;
			wdogFlag_reg <= 1'b0;
			wdogArm_reg  <= 1'b0;
			reset_output_enable_reg    <= 1'b0;
			irq_reg      <= 1'b0;
			intRst_reg   <= 1'b0;
			extRst_reg   <= 1'b0;
		end else begin
			prescale_reg <= prescale_next;
			count_reg    <= count_next;
			wrapFlag_reg <= wrapFlag_next;
			mode_reg     <= mode_next;
			run_reg      <= run_next;
			cks_reg      <= cks_next;
			wrapArm_reg  <= wrapArm_next;
			wdogFlag_reg <= wdogFlag_next;
			wdogArm_reg  <= wdogArm_next;
			reset_output_enable_reg    <= reset_output_enable_next;
			irq_reg      <= irq_next;
			intRst_reg   <= intRst_next;
			extRst_reg   <= extRst_next;
		end
	end
	// outputs straight from flops
	assign avs_readdata    = readData_reg;
	assign avs_waitrequest = waitReq_reg;
	assign intervalIrq     = irq_reg;
	assign internalReset   = intRst_reg;
	assign resetOut        = extRst_reg;
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence s_wdtPulse;
		intRst_reg ##1 (!intRst_reg && !run_reg && count_reg == `WDIT_COUNT_RESET);
	endsequence
	property p_stopHolds;
		!run_reg |=> (count_reg == `WDIT_COUNT_RESET);
	endproperty
	a_stopHolds: assert property (p_stopHolds) else $error("counter not held while stopped");
	property p_irqCause;
		irq_reg |-> (run_reg && !mode_reg && wrapFlag_reg);
	endproperty
	a_irqCause: assert property (p_irqCause) else $error("interrupt without running interval overflow");
	property p_intervalIrq;
		(overflow && !mode_reg && !doWrite) |=> irq_reg && !intRst_reg;
	endproperty
	a_intervalIrq: assert property (p_intervalIrq) else $error("interval overflow gave no interrupt");
	property p_wdtReset;
		(overflow && mode_reg) |=> s_wdtPulse;
	endproperty
	a_wdtReset: assert property (p_wdtReset) else $error("watchdog overflow gave no reset pulse");
	property p_div2;
		(run_reg && cks_reg == 3'h0 && tick) |=> !tick;
	endproperty
	a_div2: assert property (p_div2) else $error("divide by two ticked twice in a row");
	property p_wrapSet;
		overflow |=> wrapFlag_reg;
	endproperty
	a_wrapSet: assert property (p_wrapSet) else $error("overflow flag not set on wrap");
	property p_noBlindClear;
		(wrapFlag_reg && !wrapArm_reg && !intRst_reg) |=> wrapFlag_reg;
	endproperty
	a_noBlindClear: assert property (p_noBlindClear) else $error("flag cleared without prior read");
	property p_oneIgnored;
		(!wrapFlag_reg && !overflow && doWrite && wordIdx == `WDIT_IDX_CTRL_STATUS) |=> !wrapFlag_reg;
	endproperty
	a_oneIgnored: assert property (p_oneIgnored) else $error("write set the overflow flag");
	property p_extGate;
		resetOut |-> (internalReset && $past(reset_output_enable_reg));
	endproperty
	a_extGate: assert property (p_extGate) else $error("external reset while output disabled");
	property p_wdogSet;
		(overflow && mode_reg) |=> wdogFlag_reg;
	endproperty
	a_wdogSet: assert property (p_wdogSet) else $error("reset flag not set by watchdog");
	property p_countLoad;
		(doWrite && wordIdx == `WDIT_IDX_COUNT && run_reg && !intRst_reg) |=> (count_reg == $past(wdata));
	endproperty
	a_countLoad: assert property (p_countLoad) else $error("counter write not loaded");
endmodule // wdit_watchdog_timer
